// ===== wwt_pkg.sv
package wwt_pkg;
    // Register byte offsets
    localparam logic [5:0] OFS_MODE = 6'h00;
    localparam logic [5:0] OFS_TIMEOUT = 6'h04;
    localparam logic [5:0] OFS_FEED = 6'h08;
    localparam logic [5:0] OFS_COUNT = 6'h0c;
    localparam logic [5:0] OFS_WINDOW = 6'h10;
    localparam logic [5:0] OFS_WARN = 6'h14;
    localparam logic [5:0] OFS_STATUS = 6'h18;
    localparam logic [5:0] OFS_MASK = 6'h1c;
    localparam logic [5:0] OFS_RSTFLAG = 6'h20;
    // Mode bit positions
    localparam int MODE_EN = 0;
    localparam int MODE_RST_EN = 1;
    localparam int MODE_WIN_EN = 2;
    localparam int MODE_WARN_EN = 3;
    localparam int MODE_FE_RST = 4;
    localparam int MODE_FE_IRQ = 5;
    // Status bit positions
    localparam int STS_WARN = 0;
    localparam int STS_FAULT = 1;
    localparam int STS_EXPIRE = 2;
    // Values after reset
    localparam logic [5:0] MODE_RST = 6'h00;
    localparam logic [23:0] TIMEOUT_RST = 24'hffffff;
    localparam logic [23:0] WINDOW_RST = 24'hffffff;
    localparam logic [23:0] WARN_RST = 24'h000000;
    localparam logic [2:0] MASK_RST = 3'h0;
    // Counting
    localparam logic [23:0] TIMEOUT_MIN = 24'h000100;
    localparam logic [1:0] PRESC_LAST = 2'h3;
    localparam logic [7:0] FEED_FIRST = 8'haa;
    localparam logic [7:0] FEED_SECOND = 8'h55;
    // Chip reset pulse length
    localparam int CLK_PERIOD_NS = 50;
    localparam int CHIP_RST_NS = 1000;
    localparam int CHIP_RST_CYC = (CHIP_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic {FEED_IDLE, FEED_ARMED} wwt_feed_t;
endpackage

// ===== wwt_top.sv
// How it works
// - Counter reaching zero without reload asserts the chip reset output if reset is enabled, else sets expiry status.
// - In window mode a reload above the window value is a fault.
// - Warning status sets when counter equals warning value, if enabled.
// - Enable bit is set-only; reset, expiry or fault response clears it.
// - Malformed feed sequence resets chip or raises interrupt as enabled.
// - A sticky flag records that this block reset the chip.
// - 24-bit down-counter ticks once per four watchdog clock rising edges.
// - Time-out writes below 256 ticks are raised to 256.
// - Watchdog clock is the internal RC oscillator input, synchronised.
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
module wwt_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Watchdog clock from the internal RC oscillator
    input wire logic internal_rc_oscillator,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Chip reset and interrupt
    output logic chip_rst,
    output logic irq
);
    import wwt_pkg::*;

    logic [2:0] rc_sync_q;
    logic rc_lvl_q;
    logic [1:0] presc_q;
    logic [5:0] mode_q;
    logic [5:0] mode_d;
    logic [23:0] timeout_q;
    logic [23:0] window_q;
    logic [23:0] warn_q;
    logic [23:0] cnt_q;
    logic [23:0] cnt_d;
    logic [2:0] sts_q;
    logic [2:0] mask_q;
    logic rst_flag_q;
    logic [4:0] rst_cnt_q;
    logic [4:0] rst_cnt_d;
    logic wait_q;
    logic [31:0] rdata_q;
    logic chip_rst_q;
    logic irq_q;
    wwt_feed_t feed_q;
    wwt_feed_t feed_d;

    // Bus decode
    wire req = read | write;
    wire go = req & ~wait_q;
    wire wr_ok = go & write & (byteenable == 4'hf);
    wire sel_mode = address == OFS_MODE;
    wire sel_timeout = address == OFS_TIMEOUT;
    wire sel_feed = address == OFS_FEED;
    wire sel_count = address == OFS_COUNT;
    wire sel_window = address == OFS_WINDOW;
    wire sel_warn = address == OFS_WARN;
    wire sel_status = address == OFS_STATUS;
    wire sel_mask = address == OFS_MASK;
    wire sel_rstflag = address == OFS_RSTFLAG;
    wire [31:0] rd_mux =
        sel_mode ? {26'h0, mode_q} :
        sel_timeout ? {8'h0, timeout_q} :
        sel_count ? {8'h0, cnt_q} :
        sel_window ? {8'h0, window_q} :
        sel_warn ? {8'h0, warn_q} :
        sel_status ? {29'h0, sts_q} :
        sel_mask ? {29'h0, mask_q} :
        sel_rstflag ? {31'h0, rst_flag_q} : 32'h0;

    // Watchdog clock edge and prescaler
    wire rc_rise = rc_sync_q[1] & rc_sync_q[2] & ~rc_lvl_q;
    wire tick = rc_rise & (presc_q == PRESC_LAST);

    // Mode fields
    wire en = mode_q[MODE_EN];
    wire rst_en = mode_q[MODE_RST_EN];
    wire win_en = mode_q[MODE_WIN_EN];
    wire warn_en = mode_q[MODE_WARN_EN];
    wire fe_rst = mode_q[MODE_FE_RST];
    wire fe_irq = mode_q[MODE_FE_IRQ];

    // Feed sequence checks
    wire armed = feed_q == FEED_ARMED;
    wire feed_wr = wr_ok & sel_feed;
    wire feed_one = feed_wr & (writedata[7:0] == FEED_FIRST);
    wire feed_two = armed & feed_wr & (writedata[7:0] == FEED_SECOND);
    wire bad_seq = go & ((armed & ~feed_two) | (~armed & write & sel_feed & ~feed_one));
    wire win_fault = feed_two & win_en & (cnt_q > window_q);
    wire fault = en & (bad_seq | win_fault);
    wire reload = feed_two & ~win_fault;

    // Events
    wire expire = en & tick & (cnt_q == 24'h0);
    wire warn_hit = en & warn_en & tick & (cnt_q == warn_q);
    wire rst_trig = (expire & rst_en) | (fault & fe_rst);
    wire stop = expire | rst_trig | (fault & fe_irq);
    wire [2:0] sts_set = {expire & ~rst_en, fault & fe_irq, warn_hit};
    wire [2:0] sts_clr = (wr_ok & sel_status) ? writedata[2:0] : 3'h0;
    wire [2:0] sts_d = sts_set | (sts_q & ~sts_clr);
    wire [23:0] timeout_w = (writedata[23:0] < TIMEOUT_MIN) ? TIMEOUT_MIN : writedata[23:0];

    always_comb begin
        mode_d = mode_q;
        if (wr_ok && sel_mode) begin
            mode_d = writedata[5:0] | {5'h0, en};
        end
        if (stop) begin
            mode_d[MODE_EN] = 1'b0;
        end
    end

    always_comb begin
        cnt_d = cnt_q;
        if (!en || reload) begin
            cnt_d = timeout_q;
        end else if (tick) begin
            cnt_d = (cnt_q == 24'h0) ? timeout_q : cnt_q - 24'h1;
        end
    end

    always_comb begin
        feed_d = feed_q;
        if (go) begin
            unique case (feed_q)
                FEED_IDLE: begin
                    feed_d = feed_one ? FEED_ARMED : FEED_IDLE;
                end
                FEED_ARMED: begin
                    feed_d = FEED_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        rst_cnt_d = rst_cnt_q;
        if (rst_trig) begin
            rst_cnt_d = 5'(CHIP_RST_CYC);
        end else if (rst_cnt_q != 5'h0) begin
            rst_cnt_d = rst_cnt_q - 5'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rc_sync_q <= 3'h0;
            rc_lvl_q <= 1'b0;
        end else begin
            rc_sync_q <= {rc_sync_q[1:0], internal_rc_oscillator};
            if (rc_sync_q[1] == rc_sync_q[2]) begin
                rc_lvl_q <= rc_sync_q[2];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            presc_q <= 2'h0;
        end else if (rc_rise) begin
            presc_q <= presc_q + 2'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mode_q <= MODE_RST;
            cnt_q <= TIMEOUT_RST;
            feed_q <= FEED_IDLE;
        end else begin
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            feed_q <= feed_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            timeout_q <= TIMEOUT_RST;
        end else if (wr_ok && sel_timeout) begin
            timeout_q <= timeout_w;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            window_q <= WINDOW_RST;
            warn_q <= WARN_RST;
            mask_q <= MASK_RST;
        end else begin
            if (wr_ok && sel_window) begin
                window_q <= writedata[23:0];
            end
            if (wr_ok && sel_warn) begin
                warn_q <= writedata[23:0];
            end
            if (wr_ok && sel_mask) begin
                mask_q <= writedata[2:0];
            end
        end
    end

    // Sticky status and interrupt
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sts_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            sts_q <= sts_d;
            irq_q <= |(sts_d & mask_q);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rst_flag_q <= 1'b0;
        end else if (rst_trig) begin
            rst_flag_q <= 1'b1;
        end else if (wr_ok && sel_rstflag && writedata[0]) begin
            rst_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rst_cnt_q <= 5'h0;
            chip_rst_q <= 1'b0;
        end else begin
            rst_cnt_q <= rst_cnt_d;
            chip_rst_q <= rst_cnt_d != 5'h0;
        end
    end

    // Bus answer, one wait state
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            wait_q <= ~(req & wait_q);
            if (req && wait_q) begin
                rdata_q <= read ? rd_mux : 32'h0;
            end
        end
    end

    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign chip_rst = chip_rst_q;
    assign irq = irq_q;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_expire_rst;
        expire && rst_en |=> chip_rst_q [*3];
    endproperty
    a_expire_rst: assert property (p_expire_rst) else $error("no chip reset on expiry");

    property p_win_fault;
        win_fault && en && fe_irq |=> sts_q[STS_FAULT] && !mode_q[MODE_EN];
    endproperty
    a_win_fault: assert property (p_win_fault) else $error("window fault missed");

    property p_warn;
        en && warn_en && tick && cnt_q == warn_q |=> sts_q[STS_WARN];
    endproperty
    a_warn: assert property (p_warn) else $error("warning not raised");

    property p_en_hold;
        en && !stop |=> mode_q[MODE_EN];
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable dropped");

    property p_feed_rst;
        bad_seq && en && fe_rst |=> chip_rst_q ##1 chip_rst_q;
    endproperty
    a_feed_rst: assert property (p_feed_rst) else $error("bad feed did not reset");

    property p_flag;
        $rose(chip_rst_q) |-> rst_flag_q;
    endproperty
    a_flag: assert property (p_flag) else $error("reset flag not set");

    property p_presc;
        tick |=> !tick [*3];
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler too fast");

    property p_min;
        timeout_q >= TIMEOUT_MIN;
    endproperty
    a_min: assert property (p_min) else $error("time-out below minimum");

    property p_reload;
        reload && en |=> cnt_q == $past(timeout_q);
    endproperty
    a_reload: assert property (p_reload) else $error("reload lost");

    property p_bus;
        req && wait_q |=> !wait_q ##1 wait_q;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer late");

    property p_irq;
        $stable(mask_q) |-> irq_q == |(sts_q & mask_q);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    property p_rc_edge;
        rc_rise |=> rc_lvl_q;
    endproperty
    a_rc_edge: assert property (p_rc_edge) else $error("watchdog clock edge lost");

    property p_count;
        en && tick && cnt_q != 24'h0 && !reload |=> cnt_q == $past(cnt_q) - 24'h1;
    endproperty
    a_count: assert property (p_count) else $error("count step wrong");

    property p_en_set;
        !en && !(wr_ok && sel_mode && writedata[MODE_EN]) |=> !mode_q[MODE_EN];
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable rose without a write");

    property p_flag_set;
        rst_trig |=> rst_flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("reset flag missed");
endmodule // wwt_top

// ===== wwt_top_tb.sv
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module wwt_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import wwt_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic internal_rc_oscillator = 1'b0;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic chip_rst;
    logic irq;
    int n_errors = 0;
    int tests_run = 0;

    wwt_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .internal_rc_oscillator(internal_rc_oscillator),
        .address(address), .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .chip_rst(chip_rst), .irq(irq));

    always #25 clk_sys = ~clk_sys;

    // Watchdog clock, unrelated in phase
    initial begin
        #37;
        forever #200 internal_rc_oscillator = ~internal_rc_oscillator;
    end

    // Bus access: hold until waitrequest low, then release
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        read <= ~w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        `CHK(waitrequest, 1'b0)
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        acc(1'b1, a, d, r);
    endtask

    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] r;
        acc(1'b0, a, 32'h0, r);
        `CHK(r, e)
    endtask

    // Wait for chip reset, then measure its length
    task automatic wait_rst(input int lim);
        int n;
        n = 0;
        while (chip_rst !== 1'b1 && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(chip_rst, 1'b1)
        n = 0;
        while (chip_rst === 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(n, CHIP_RST_CYC)
    endtask

    task automatic t_reset_vals;
        rdc(OFS_MODE, 32'h0);
        rdc(OFS_TIMEOUT, 32'h00ffffff);
        rdc(OFS_WINDOW, 32'h00ffffff);
        rdc(OFS_RSTFLAG, 32'h0);
        rdc(6'h3c, 32'h0);
        wr(OFS_TIMEOUT, 32'h10);
        rdc(OFS_TIMEOUT, 32'h100);
        rdc(OFS_COUNT, 32'h100);
        byteenable <= 4'h1;
        wr(OFS_WINDOW, 32'h0);
        byteenable <= 4'hf;
        rdc(OFS_WINDOW, 32'h00ffffff);
    endtask

    task automatic t_lock_fault;
        wr(OFS_MODE, 32'h21);
        wr(OFS_MODE, 32'h20);
        rdc(OFS_MODE, 32'h21);
        wr(OFS_FEED, 32'haa);
        rdc(OFS_TIMEOUT, 32'h100);
        rdc(OFS_STATUS, 32'h2);
        rdc(OFS_MODE, 32'h20);
        `CHK(irq, 1'b0)
        wr(OFS_MASK, 32'h2);
        repeat (2) @(posedge clk_sys);
        `CHK(irq, 1'b1)
        wr(OFS_STATUS, 32'h2);
        repeat (2) @(posedge clk_sys);
        `CHK(irq, 1'b0)
    endtask

    task automatic t_warning;
        logic [31:0] r;
        wr(OFS_WARN, 32'hfe);
        wr(OFS_MASK, 32'h1);
        wr(OFS_MODE, 32'h09);
        repeat (300) @(posedge clk_sys);
        `CHK(irq, 1'b1)
        rdc(OFS_STATUS, 32'h1);
        wr(OFS_FEED, 32'haa);
        wr(OFS_FEED, 32'h55);
        acc(1'b0, OFS_COUNT, 32'h0, r);
        `CHK(r[23:0] > 24'hfe, 1'b1)
        rdc(OFS_STATUS, 32'h1);
    endtask

    task automatic t_window;
        wr(OFS_WARN, 32'h0);
        wr(OFS_STATUS, 32'h1);
        wr(OFS_WINDOW, 32'h80);
        wr(OFS_MODE, 32'h24);
        wr(OFS_FEED, 32'haa);
        wr(OFS_FEED, 32'h55);
        rdc(OFS_STATUS, 32'h2);
        rdc(OFS_MODE, 32'h24);
    endtask

    task automatic t_expiry;
        wr(OFS_STATUS, 32'h7);
        wr(OFS_WINDOW, 32'hffffff);
        wr(OFS_MODE, 32'h03);
        wait_rst(12000);
        rdc(OFS_RSTFLAG, 32'h1);
        rdc(OFS_MODE, 32'h02);
        wr(OFS_RSTFLAG, 32'h1);
        rdc(OFS_RSTFLAG, 32'h0);
    endtask

    task automatic t_expiry_irq;
        int n;
        n = 0;
        wr(OFS_MASK, 32'h4);
        wr(OFS_MODE, 32'h01);
        while (irq !== 1'b1 && n < 9000) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(irq, 1'b1)
        `CHK(chip_rst, 1'b0)
        rdc(OFS_STATUS, 32'h4);
        rdc(OFS_MODE, 32'h0);
        rdc(OFS_RSTFLAG, 32'h0);
        wr(OFS_STATUS, 32'h4);
        repeat (2) @(posedge clk_sys);
        `CHK(irq, 1'b0)
    endtask

    task automatic t_hw_reset;
        rst_b <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rdc(OFS_RSTFLAG, 32'h0);
        rdc(OFS_MODE, 32'h0);
        rdc(OFS_TIMEOUT, 32'h00ffffff);
    endtask

    task automatic t_feed_rst;
        wr(OFS_MODE, 32'h11);
        wr(OFS_FEED, 32'h12);
        wait_rst(10);
        rdc(OFS_RSTFLAG, 32'h1);
    endtask

    task automatic wrap_up;
        if (n_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        t_reset_vals();
        t_lock_fault();
        t_warning();
        t_window();
        t_expiry();
        t_expiry_irq();
        t_feed_rst();
        t_hw_reset();
        wrap_up();
    end
endmodule // wwt_top_tb
